// ===== rtl/spi_config_defs.vh
/*
 Constants for the configuration and identification register group:
 offsets, field positions, reset values and the soft reset hold time.
 Assumes inclusion by bare name from the register group module.
*/
`ifndef SPI_CONFIG_DEFS_VH
`define SPI_CONFIG_DEFS_VH

`define ADDR_PRIMARY_CONFIG 15'h0000
`define ADDR_POWER_MODE 15'h0002
`define ADDR_DEVICE_CATEGORY 15'h0003
`define ADDR_FAMILY_LO 15'h0004
`define ADDR_FAMILY_HI 15'h0005
`define ADDR_ADDRESS_HOLD 15'h0010

`define BIT_SOFT_RESET 7
`define BIT_ASCEND 5
`define BIT_SEPARATE_OUTPUT 4
`define MODE_NORMAL 2'h0
`define MODE_POWER_DOWN 2'h3

`define RST_PRIMARY_CONFIG 8'h30
`define RST_POWER_MODE 8'h00
`define RST_CATEGORY_HI 4'h0
`define RST_ADDRESS_HOLD 8'h00

`define HDR_BITS 16
`define CLK_PERIOD_NS 40
`define SOFT_RESET_NS 750
`define SOFT_RESET_CYCLES \
  ((`SOFT_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== rtl/spi_config_id_registers.v
/*
 Front configuration and identification registers behind a serial port
 (mode 0: sample on rising clock, shift out on falling clock).
 Assumes the serial pins are asynchronous to ref_clk and that the serial
 clock is at most one eighth of ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "spi_config_defs.vh"

module spi_config_id_registers
#(
  // Value arbitrary
  parameter [3:0] CATEGORY_CODE = 4'h5,
  // Value arbitrary
  parameter [15:0] FAMILY_CODE = 16'h1234
)
(
  input wire ref_clk,
  input wire resetn,
  input wire spi_sclk,
  input wire spi_csn,
  input wire spi_sdi,
  output reg spi_sdo,
  output reg core_reset,
  output reg [1:0] op_mode,
  output reg power_down
);

  localparam integer SR_CYCLES_I = `SOFT_RESET_CYCLES;
  // Count fits five bits; cut on purpose
  localparam [4:0] SR_CYCLES = SR_CYCLES_I[4:0];
  localparam [7:0] RST_CFG = `RST_PRIMARY_CONFIG;

  reg sclk_s1_q, sclk_s2_q, sclk_s3_q;
  reg csn_s1_q, csn_s2_q;
  reg sdi_s1_q, sdi_s2_q;
  reg in_hdr_q;
  reg rd_q;
  reg [3:0] cnt_q;
  reg [15:0] rx_q;
  reg [7:0] tx_q;
  reg [14:0] addr_q;
  reg [4:0] sr_cnt_q;
  reg cfg_b6_q;
  reg cfg_asc_q;
  reg [3:0] cfg_lo_q;
  reg [7:0] mode_q;
  reg [3:0] cat_hi_q;
  reg [7:0] hold_q;

  wire sclk_rise = sclk_s2_q & ~sclk_s3_q;
  wire sclk_fall = ~sclk_s2_q & sclk_s3_q;
  wire [15:0] rx_full = {rx_q[14:0], sdi_s2_q};

  function [7:0] read_byte;
    input [14:0] a;
    begin
      case (a)
        `ADDR_PRIMARY_CONFIG:
          read_byte = {1'b0, cfg_b6_q, cfg_asc_q, 1'b1, cfg_lo_q};
        `ADDR_POWER_MODE:
          read_byte = mode_q;
        `ADDR_DEVICE_CATEGORY:
          read_byte = {cat_hi_q, CATEGORY_CODE};
        `ADDR_FAMILY_LO:
          read_byte = FAMILY_CODE[7:0];
        `ADDR_FAMILY_HI:
          read_byte = FAMILY_CODE[15:8];
        `ADDR_ADDRESS_HOLD:
          read_byte = hold_q;
        default:
          read_byte = 8'h00;
      endcase
    end
  endfunction

  // Hold wins over direction
  wire [14:0] next_addr = hold_q[0] ? addr_q :
    (cfg_asc_q ? addr_q + 15'h0001 : addr_q - 15'h0001);

  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      csn_s1_q <= 1'b1;
      csn_s2_q <= 1'b1;
      sdi_s1_q <= 1'b0;
      sdi_s2_q <= 1'b0;
    end
    else
    begin
      sclk_s1_q <= spi_sclk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      csn_s1_q <= spi_csn;
      csn_s2_q <= csn_s1_q;
      sdi_s1_q <= spi_sdi;
      sdi_s2_q <= sdi_s1_q;
    end
  end

  // Serial frame: 1 read/write bit, 15 address bits, then streamed bytes
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      in_hdr_q <= 1'b1;
      rd_q <= 1'b0;
      cnt_q <= 4'h0;
      rx_q <= 16'h0000;
      tx_q <= 8'h00;
      addr_q <= 15'h0000;
      spi_sdo <= 1'b0;
    end
    else if (csn_s2_q)
    begin
      in_hdr_q <= 1'b1;
      rd_q <= 1'b0;
      cnt_q <= 4'h0;
      spi_sdo <= 1'b0;
    end
    else if (sclk_rise)
    begin
      rx_q <= rx_full;
      cnt_q <= cnt_q + 4'h1;
      if (in_hdr_q && cnt_q == 4'hf)
      begin
        in_hdr_q <= 1'b0;
        rd_q <= rx_full[15];
        addr_q <= rx_full[14:0];
        tx_q <= read_byte(rx_full[14:0]);
        cnt_q <= 4'h0;
      end
      else if (!in_hdr_q && cnt_q[2:0] == 3'h7)
      begin
        addr_q <= next_addr;
        if (rd_q)
          tx_q <= read_byte(next_addr);
        cnt_q <= 4'h0;
      end
    end
    else if (sclk_fall && !in_hdr_q && rd_q)
    begin
      // Read data leaves only on the dedicated output pin
      spi_sdo <= tx_q[7];
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  wire byte_wr = !csn_s2_q && sclk_rise && !in_hdr_q && !rd_q &&
    cnt_q[2:0] == 3'h7 && !core_reset;
  wire soft_rst = byte_wr && addr_q == `ADDR_PRIMARY_CONFIG &&
    rx_full[`BIT_SOFT_RESET];

  // Writes are dropped while the internal reset is held, so a host that
  // ignores the wait time cannot half-configure the part.
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg_b6_q <= RST_CFG[6];
      cfg_asc_q <= RST_CFG[`BIT_ASCEND];
      cfg_lo_q <= RST_CFG[3:0];
      mode_q <= `RST_POWER_MODE;
      cat_hi_q <= `RST_CATEGORY_HI;
      hold_q <= `RST_ADDRESS_HOLD;
      sr_cnt_q <= 5'h00;
      core_reset <= 1'b0;
      op_mode <= `MODE_NORMAL;
      power_down <= 1'b0;
    end
    else
    begin
      op_mode <= mode_q[1:0];
      power_down <= (mode_q[1:0] == `MODE_POWER_DOWN);
      if (sr_cnt_q != 5'h00)
        sr_cnt_q <= sr_cnt_q - 5'h01;
      core_reset <= (sr_cnt_q > 5'h01) || soft_rst;
      if (soft_rst)
      begin
        // Reset bit is never stored, so it reads back as zero
        cfg_b6_q <= RST_CFG[6];
        cfg_asc_q <= RST_CFG[`BIT_ASCEND];
        cfg_lo_q <= RST_CFG[3:0];
        mode_q <= `RST_POWER_MODE;
        cat_hi_q <= `RST_CATEGORY_HI;
        hold_q <= `RST_ADDRESS_HOLD;
        sr_cnt_q <= SR_CYCLES;
      end
      else if (byte_wr)
      begin
        case (addr_q)
          `ADDR_PRIMARY_CONFIG:
          begin
            cfg_b6_q <= rx_full[6];
            cfg_asc_q <= rx_full[`BIT_ASCEND];
            cfg_lo_q <= rx_full[3:0];
          end
          `ADDR_POWER_MODE:
            mode_q <= rx_full[7:0];
          `ADDR_DEVICE_CATEGORY:
            cat_hi_q <= rx_full[7:4];
          `ADDR_ADDRESS_HOLD:
            hold_q <= rx_full[7:0];
          default:
            cat_hi_q <= cat_hi_q;
        endcase
      end
    end
  end

endmodule // spi_config_id_registers
`default_nettype wire

// ===== verif/spi_config_id_registers_asserts.sv
/* Port checker for the config register group.
   Assumes one clock and the bind at the foot. */
`timescale 1ns/10ps
`default_nettype none
module spi_config_id_registers_asserts (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic spi_csn,
  input wire logic spi_sdo,
  input wire logic core_reset,
  input wire logic [1:0] op_mode,
  input wire logic power_down
);
  logic [4:0] hi_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Counted, since a 19 cycle repetition is too long to unroll
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
      hi_q <= 5'h00;
    else
      hi_q <= core_reset ? hi_q + 5'h01 : 5'h00;
  a_reset_len: assert property ($fell(core_reset) |-> hi_q == 5'h13)
    else $error("soft reset length wrong");
  a_reset_mode: assert property (
    $rose(core_reset) |-> ##[0:2] op_mode == 2'h0)
    else $error("mode kept over soft reset");
  a_down_on: assert property ((op_mode == 2'h3) [*2] |-> power_down)
    else $error("power down missing");
  a_down_off: assert property ((op_mode != 2'h3) [*2] |-> !power_down)
    else $error("power down wrong");
  a_sdo_idle: assert property (spi_csn [*5] |-> !spi_sdo)
    else $error("data output busy when idle");
  a_mode_held: assert property (spi_csn [*8] |-> $stable(op_mode))
    else $error("mode changed without frame");
  a_down_held: assert property (
    (spi_csn && power_down) [*8] |=> power_down)
    else $error("power down lost");
  a_idle_values: assert property (
    $rose(resetn) |-> !core_reset && op_mode == 2'h0)
    else $error("bad value after reset");
endmodule // spi_config_id_registers_asserts
bind spi_config_id_registers spi_config_id_registers_asserts u_chk (
  .ref_clk(ref_clk), .resetn(resetn), .spi_csn(spi_csn), .spi_sdo(spi_sdo),
  .core_reset(core_reset), .op_mode(op_mode), .power_down(power_down));
`default_nettype wire

// ===== verif/spi_host_model.sv
/* Serial host model, mode 0, sclk at ref_clk/12.
   Assumes callers wait for each frame to return. */
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  input wire logic ref_clk,
  input wire logic spi_sdo,
  output logic spi_sclk,
  output logic spi_csn,
  output logic spi_sdi
);
  initial {spi_sclk, spi_csn, spi_sdi} = 3'b010;
  task automatic xfer(input logic [31:0] b, input int n,
                      output logic [15:0] r);
    r = 16'h0000;
    spi_csn = 1'b0;
    for (int i = 31; i > 31 - n; i--)
    begin
      spi_sdi = b[i];
      repeat (6) @(negedge ref_clk);
      spi_sclk = 1'b1;
      r = {r[14:0], spi_sdo};
      repeat (6) @(negedge ref_clk);
      spi_sclk = 1'b0;
    end
    repeat (6) @(negedge ref_clk);
    spi_csn = 1'b1;
    spi_sdi = ~spi_sdi;
    // Margin over 750 ns covers the synchroniser delay too
    repeat (25) @(negedge ref_clk);
  endtask
endmodule // spi_host_model
`default_nettype wire

// ===== verif/test_spi_config_id_registers.sv
/* Bench for the config register group.
   Assumes the host model drives all serial inputs; the DUT drives spi_sdo. */
`timescale 1ns/10ps
`default_nettype none
module test_spi_config_id_registers;
  localparam [3:0] CAT = 4'h9; // Value arbitrary
  localparam [15:0] FAM = 16'h5a6c; // Value arbitrary
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic spi_sclk, spi_csn, spi_sdi, spi_sdo, core_reset, power_down;
  logic [1:0] op_mode;
  logic [15:0] rd;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  always #20 ref_clk = ~ref_clk;
  spi_config_id_registers #(.CATEGORY_CODE(CAT), .FAMILY_CODE(FAM)) dut (
    .ref_clk(ref_clk), .resetn(resetn), .spi_sclk(spi_sclk),
    .spi_csn(spi_csn), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
    .core_reset(core_reset), .op_mode(op_mode), .power_down(power_down));
  spi_host_model host (.ref_clk(ref_clk), .spi_sdo(spi_sdo),
    .spi_sclk(spi_sclk), .spi_csn(spi_csn), .spi_sdi(spi_sdi));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rw(input logic [15:0] h, input logic [15:0] d, input int nb,
                    input logic [15:0] exp);
    host.xfer({h, d}, 16 + 8 * nb, rd);
    if (h[15])
      chk(nb == 2 ? rd : {8'h00, rd[7:0]}, exp);
  endtask
  task automatic t_defaults();
    rw(16'h8002, 16'h0000, 2, {12'h000, CAT});
    rw(16'h8000, 16'h0000, 1, 16'h0030);
    rw(16'h0004, 16'hffff, 2, 16'h0000);
    rw(16'h8004, 16'h0000, 2, {FAM[7:0], FAM[15:8]});
    $display("defaults done");
  endtask
  task automatic t_descend();
    rw(16'h0003, 16'haf00, 1, 16'h0000);
    rw(16'h0000, 16'h4000, 1, 16'h0000);
    rw(16'h8003, 16'h0000, 2, {4'ha, CAT, 8'h00});
    rw(16'h8000, 16'h0000, 1, 16'h0050);
    rw(16'h0010, 16'h0100, 1, 16'h0000);
    rw(16'h8003, 16'h0000, 2, {2{4'ha, CAT}});
    rw(16'h0010, 16'h0000, 1, 16'h0000);
    $display("descend and hold done");
  endtask
  task automatic t_modes();
    for (int m = 0; m < 4; m++)
    begin
      rw(16'h0002, {6'h00, m[1:0], 8'h00}, 1, 16'h0000);
      chk({13'h0000, power_down, op_mode},
          {13'h0000, m == 3, m[1:0]});
    end
    rw(16'h8002, 16'h0000, 1, 16'h0003);
    $display("modes done");
  endtask
  task automatic t_soft();
    rw(16'h0000, 16'h8000, 1, 16'h0000);
    rw(16'h8000, 16'h0000, 1, 16'h0030);
    rw(16'h8002, 16'h0000, 2, {12'h000, CAT});
    $display("soft reset done");
  endtask
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      $display("Error at %0t: timeout", $time);
      wrap_up();
    end
  end
  initial
  begin
    repeat (12) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (3) @(negedge ref_clk);
    t_defaults();
    t_descend();
    t_modes();
    t_soft();
    wrap_up();
  end
endmodule // test_spi_config_id_registers
`default_nettype wire
